// >>> design/port_input_and_interrupt_ops.sv
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module port_input_and_interrupt_ops
   import pio_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic ACK_O,
   output logic [5:0] PORT_ADDR_O,
   output logic PORT_RD_O,
   input wire logic [15:0] PORT_DATA_I,
   output logic [15:0] MEM_ADDR_O,
   output logic [15:0] MEM_WDATA_O,
   output logic MEM_WE_O,
   output logic MEM_RD_O,
   input wire logic [15:0] MEM_RDATA_I,
   input wire logic IRQ_REQ_I,
   output logic IRQ_SERVICE_O,
   output logic BUSY_O
);
   typedef enum {S_IDLE, S_EXEC, S_PORT, S_CAP, S_POP, S_LOAD} state_t;

   state_t state;
   logic [16:0] instr;
   logic [15:0] word2;
   logic [15:0] strlen;
   logic [15:0] sp;
   logic [15:0] stack_top_reg;
   logic [15:0] pc;
   logic [15:0] acc [ACC_COUNT];
   flags_t aflags;
   logic xzro;
   logic xsgn;
   logic mask;
   logic bad;
   logic [2:0] acc_ix;
   logic [15:0] samples;
   decode_t dec;
   flags_t sample_flags;
   port_req_t preq;
   mem_req_t mreq;
   logic req;
   logic wr_ok;
   logic [15:0] status;
   logic [15:0] mem_dest;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   insn_decode u_dec (
      .insn_i(instr),
      .dec_o(dec)
   );

   load_flags u_flags (
      .value_i(PORT_DATA_I),
      .flags_o(sample_flags)
   );

   assign req = CYC_I && STB_I && !ACK_O;
   // software writes only land while the core is idle
   assign wr_ok = req && WE_I && (state == S_IDLE);
   assign BUSY_O = (state != S_IDLE);
   assign PORT_ADDR_O = preq.addr;
   assign PORT_RD_O = preq.rd;
   assign MEM_ADDR_O = mreq.addr;
   assign MEM_WDATA_O = mreq.wdata;
   assign MEM_WE_O = mreq.we;
   assign MEM_RD_O = mreq.rd;

   always_comb begin
      status = '0;
      status[ST_OVF] = aflags.ovf;
      status[ST_SGN] = aflags.sgn;
      status[ST_ZRO] = aflags.zro;
      status[ST_CRY] = aflags.cry;
      status[ST_MASK] = mask;
      status[ST_XZRO] = xzro;
      status[ST_XSGN] = xsgn;
      status[ST_BAD] = bad;
      status[ST_BUSY] = BUSY_O;
   end

   // direct or long relative second word
   // pc has already stepped past both words here, so undo that step
   assign mem_dest = dec.rel ? 16'(pc - PC_STEP2 + word2) : word2;

   assign IRQ_SERVICE_O = IRQ_REQ_I && mask && (state == S_IDLE);

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         ACK_O <= 1'b0;
         DAT_O <= '0;
      end else if (CE_I) begin
         ACK_O <= req;
         DAT_O <= '0;
         if (req && !WE_I) begin
            if (hit(ADR_I, REG_INSTR)) begin
               DAT_O <= 32'(instr);
            end else if (hit(ADR_I, REG_WORD2)) begin
               DAT_O <= 32'(word2);
            end else if (hit(ADR_I, REG_STATUS)) begin
               DAT_O <= 32'(status);
            end else if (hit(ADR_I, REG_STRLEN)) begin
               DAT_O <= 32'(strlen);
            end else if (hit(ADR_I, REG_SP)) begin
               DAT_O <= 32'(sp);
            end else if (hit(ADR_I, REG_STACK_TOP)) begin
               DAT_O <= 32'(stack_top_reg);
            end else if (hit(ADR_I, REG_PC)) begin
               DAT_O <= 32'(pc);
            end else if (ADR_I[7:5] == REG_ACC_BASE[7:5]) begin
               DAT_O <= 32'(acc[ADR_I[4:2]]);
            end
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         instr <= '0;
         word2 <= '0;
         strlen <= '0;
      end else if (CE_I && wr_ok) begin
         if (hit(ADR_I, REG_INSTR)) begin
            instr[15:0] <= merge16(instr[15:0], DAT_I, SEL_I);
            if (SEL_I[2]) begin
               instr[16] <= DAT_I[16];
            end
         end
         if (hit(ADR_I, REG_WORD2)) begin
            word2 <= merge16(word2, DAT_I, SEL_I);
         end
         if (hit(ADR_I, REG_STRLEN)) begin
            strlen <= merge16(strlen, DAT_I, SEL_I);
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         state <= S_IDLE;
         preq <= '0;
         mreq <= '0;
         acc_ix <= '0;
         samples <= '0;
      end else if (CE_I) begin
         preq.rd <= 1'b0;
         mreq.rd <= 1'b0;
         mreq.we <= 1'b0;
         unique case (state)
            S_IDLE: begin
               // a write to the instruction word starts execution
               if (wr_ok && hit(ADR_I, REG_INSTR)) begin
                  state <= S_EXEC;
               end
            end
            S_EXEC: begin
               acc_ix <= dec.acc;
               samples <= '0;
               if (dec.in_mem || dec.in_acc || dec.in_str) begin
                  preq.addr <= dec.port;
                  preq.rd <= 1'b1;
                  state <= S_CAP;
               end else if (dec.irq_ret) begin
                  state <= S_POP;
               end else begin
                  state <= S_IDLE;
               end
            end
            S_PORT: begin
               preq.rd <= 1'b1;
               state <= S_CAP;
            end
            S_CAP: begin
               samples <= 16'(samples + PC_STEP1);
               acc_ix <= 3'(acc_ix + 3'h1);
               if (dec.in_mem) begin
                  mreq.addr <= mem_dest;
                  mreq.wdata <= PORT_DATA_I;
                  mreq.we <= 1'b1;
                  state <= S_IDLE;
               end else if (dec.in_str && (samples + PC_STEP1 < 17'(strlen) + 17'(STR_EXTRA))) begin
                  state <= S_PORT;
               end else begin
                  state <= S_IDLE;
               end
            end
            S_POP: begin
               mreq.addr <= 16'(sp - SP_POP);
               mreq.rd <= 1'b1;
               state <= S_LOAD;
            end
            S_LOAD: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < ACC_COUNT; i++) begin
            acc[i] <= RST16;
         end
      end else if (CE_I && state == S_CAP && !dec.in_mem) begin
         acc[acc_ix] <= PORT_DATA_I;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         aflags <= '0;
         xzro <= 1'b0;
         xsgn <= 1'b0;
         mask <= 1'b0;
         bad <= 1'b0;
      end else if (CE_I) begin
         if (wr_ok && hit(ADR_I, REG_STATUS) && SEL_I[0]) begin
            aflags <= {DAT_I[ST_OVF], DAT_I[ST_SGN], DAT_I[ST_ZRO], DAT_I[ST_CRY]};
            mask <= DAT_I[ST_MASK];
            xzro <= DAT_I[ST_XZRO];
            xsgn <= DAT_I[ST_XSGN];
         end
         if (wr_ok && hit(ADR_I, REG_STATUS) && SEL_I[1] && DAT_I[ST_BAD]) begin
            bad <= 1'b0;
         end
         if (state == S_EXEC) begin
            if (dec.irq_dis) begin
               mask <= 1'b0;
            end else if (dec.irq_en) begin
               mask <= 1'b1;
            end else if (!(dec.in_mem || dec.in_acc || dec.in_str || dec.irq_ret)) begin
               bad <= 1'b1;
            end
         end
         if (state == S_CAP) begin
            if (dec.in_mem) begin
               xzro <= sample_flags.zro;
               xsgn <= sample_flags.sgn;
            end else begin
               aflags <= sample_flags;
            end
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         pc <= RST16;
         sp <= RST16;
         stack_top_reg <= RST16;
      end else if (CE_I) begin
         if (wr_ok && hit(ADR_I, REG_PC)) begin
            pc <= merge16(pc, DAT_I, SEL_I);
         end
         if (wr_ok && hit(ADR_I, REG_SP)) begin
            sp <= merge16(sp, DAT_I, SEL_I);
         end
         if (wr_ok && hit(ADR_I, REG_STACK_TOP)) begin
            stack_top_reg <= merge16(stack_top_reg, DAT_I, SEL_I);
         end
         if (state == S_EXEC && !dec.irq_ret) begin
            pc <= 16'(pc + (dec.in_mem ? PC_STEP2 : PC_STEP1));
         end
         if (state == S_POP) begin
            pc <= stack_top_reg;
            sp <= 16'(sp - SP_POP);
         end
         if (state == S_LOAD) begin
            stack_top_reg <= MEM_RDATA_I;
         end
      end
   end
endmodule

// >>> design/pio_pkg.sv
package pio_pkg;
   // wishbone byte addresses
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_WORD2 = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_STRLEN = 8'h0c;
   localparam logic [7:0] REG_SP = 8'h10;
   localparam logic [7:0] REG_STACK_TOP = 8'h14;
   localparam logic [7:0] REG_PC = 8'h18;
   localparam logic [7:0] REG_ACC_BASE = 8'h20;
   localparam int ACC_COUNT = 8;
   // status bit positions
   localparam int ST_OVF = 0;
   localparam int ST_SGN = 1;
   localparam int ST_ZRO = 2;
   localparam int ST_CRY = 3;
   localparam int ST_MASK = 4;
   localparam int ST_XZRO = 5;
   localparam int ST_XSGN = 6;
   localparam int ST_BAD = 14;
   localparam int ST_BUSY = 15;
   // opcode patterns
   localparam logic [16:0] OP_IRQ_DIS = 17'h1fe90;
   localparam logic [16:0] OP_IRQ_EN = 17'h1fe80;
   localparam logic [16:0] OP_IRQ_RET = 17'h1bd7e;
   localparam logic [4:0] OP_IN_MEM = 5'h18;
   localparam logic [6:0] OP_IN_ACC = 7'h76;
   localparam logic [6:0] OP_IN_STR = 7'h77;
   // field positions
   localparam int F_TOP5 = 12;
   localparam int F_TOP7 = 10;
   localparam int F_P4_LO = 8;
   localparam int F_P6_LO = 2;
   localparam int F_ACC_LO = 8;
   localparam int F_STR_ZERO = 1;
   localparam int F_OFS = 0;
   localparam int F_REL = 7;
   // constants
   localparam logic [15:0] PC_STEP1 = 16'h0001;
   localparam logic [15:0] PC_STEP2 = 16'h0002;
   localparam logic [15:0] SP_POP = 16'h0002;
   localparam logic [15:0] STR_EXTRA = 16'h0002;
   localparam logic [15:0] RST16 = 16'h0000;
   localparam int SHORT_PORT_SHIFT = 2;

   typedef struct packed {
      logic in_mem;
      logic in_acc;
      logic in_str;
      logic irq_dis;
      logic irq_en;
      logic irq_ret;
      logic [2:0] acc;
      logic [5:0] port;
      logic rel;
   } decode_t;

   typedef struct packed {
      logic ovf;
      logic sgn;
      logic zro;
      logic cry;
   } flags_t;

   typedef struct packed {
      logic rd;
      logic [5:0] addr;
   } port_req_t;

   typedef struct packed {
      logic rd;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;
endpackage

// >>> design/insn_decode.sv
`timescale 1ns/1ps
module insn_decode
   import pio_pkg::*;
(
   input wire logic [16:0] insn_i,
   output decode_t dec_o
);
   logic [4:0] top5;
   logic [6:0] top7;

   assign top5 = insn_i[16:F_TOP5];
   assign top7 = insn_i[16:F_TOP7];

   always_comb begin
      dec_o = '0;
      dec_o.irq_dis = (insn_i == OP_IRQ_DIS);
      dec_o.irq_en = (insn_i == OP_IRQ_EN);
      dec_o.irq_ret = (insn_i == OP_IRQ_RET);
      dec_o.in_mem = (top5 == OP_IN_MEM);
      dec_o.in_acc = (top7 == OP_IN_ACC);
      dec_o.in_str = (top7 == OP_IN_STR) && !insn_i[F_STR_ZERO];
      dec_o.acc = {insn_i[F_OFS], insn_i[F_ACC_LO+1:F_ACC_LO]};
      dec_o.rel = insn_i[F_REL];
      if (dec_o.in_mem) begin
         dec_o.port = 6'(insn_i[F_P4_LO+3:F_P4_LO]) << SHORT_PORT_SHIFT;
      end else begin
         dec_o.port = insn_i[F_P6_LO+5:F_P6_LO];
      end
   end
endmodule

// >>> design/load_flags.sv
`timescale 1ns/1ps
module load_flags
   import pio_pkg::*;
(
   input wire logic [15:0] value_i,
   output flags_t flags_o
);
   // a plain load never overflows or carries
   always_comb begin
      flags_o.ovf = 1'b0;
      flags_o.cry = 1'b0;
      flags_o.sgn = value_i[15];
      flags_o.zro = (value_i == RST16);
   end
endmodule

// >>> testbench/pio_chk.sv
`timescale 1ns/1ps
module pio_chk (
   input logic MCLK_I,
   input logic SRST_I,
   input logic CYC_I,
   input logic STB_I,
   input logic ACK_O,
   input logic [31:0] DAT_O,
   input logic PORT_RD_O,
   input logic [5:0] PORT_ADDR_O,
   input logic MEM_RD_O,
   input logic MEM_WE_O,
   input logic IRQ_REQ_I,
   input logic IRQ_SERVICE_O,
   input logic BUSY_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SRST_I);
   property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack1; ACK_O |=> !ACK_O; endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_dat0; !ACK_O |-> DAT_O == 32'h0; endproperty
   a_dat0: assert property (p_dat0) else $error("read data outside ack");
   property p_svc; IRQ_SERVICE_O |-> IRQ_REQ_I && !BUSY_O; endproperty
   a_svc: assert property (p_svc) else $error("service without request");
   property p_rd1; PORT_RD_O |-> BUSY_O ##1 !PORT_RD_O; endproperty
   a_rd1: assert property (p_rd1) else $error("port read pulse wrong");
   property p_same; PORT_RD_O && $past(PORT_RD_O, 2) |-> $stable(PORT_ADDR_O); endproperty
   a_same: assert property (p_same) else $error("string port moved");
   property p_mrd; MEM_RD_O |=> !MEM_RD_O && !MEM_WE_O; endproperty
   a_mrd: assert property (p_mrd) else $error("stack read pulse wrong");
   property p_mwe; MEM_WE_O |=> !MEM_WE_O; endproperty
   a_mwe: assert property (p_mwe) else $error("store pulse too long");
   property p_busy; $rose(BUSY_O) |-> ##[1:60] !BUSY_O; endproperty
   a_busy: assert property (p_busy) else $error("execution hangs");
   c_str: cover property (PORT_RD_O ##2 PORT_RD_O);
   c_ret: cover property (MEM_RD_O);
   c_svc: cover property (IRQ_SERVICE_O);
endmodule
bind port_input_and_interrupt_ops pio_chk u_chk (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
   .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .PORT_RD_O(PORT_RD_O),
   .PORT_ADDR_O(PORT_ADDR_O), .MEM_RD_O(MEM_RD_O), .MEM_WE_O(MEM_WE_O),
   .IRQ_REQ_I(IRQ_REQ_I), .IRQ_SERVICE_O(IRQ_SERVICE_O), .BUSY_O(BUSY_O));

// >>> testbench/port_model.sv
`timescale 1ns/1ps
module port_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] port_addr_i,
   input wire logic port_rd_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] mem_addr_i,
   output logic [15:0] port_data_o,
   output logic [15:0] mem_rdata_o
);
   logic [5:0] cnt;
   logic [15:0] junk;
   // core captures at the edge that ends the read pulse, so answer within it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 6'h00;
         junk <= 16'hffff;
      end else begin
         junk <= ~junk;
         if (port_rd_i) begin
            cnt <= cnt + 6'h01;
         end
      end
   end
   assign port_data_o = port_rd_i ? {port_addr_i, 4'h0, cnt} : junk;
   assign mem_rdata_o = mem_rd_i ? (mem_addr_i ^ 16'h5a5a) : ~junk;
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import pio_pkg::*;
   logic MCLK_I = 1'b0;
   logic SRST_I = 1'b1;
   logic WE_I = 1'b0;
   logic CYC_I = 1'b0;
   logic STB_I = 1'b0;
   logic IRQ_REQ_I = 1'b0;
   logic [7:0] ADR_I = 8'h00;
   logic [31:0] DAT_I = 32'h0;
   logic [3:0] SEL_I = 4'h0;
   logic [31:0] DAT_O, q, p0;
   logic ACK_O, PORT_RD_O, MEM_WE_O, MEM_RD_O, IRQ_SERVICE_O, BUSY_O;
   logic [5:0] PORT_ADDR_O;
   logic [15:0] PORT_DATA_I, MEM_ADDR_O, MEM_WDATA_O, MEM_RDATA_I, wa, wd, ra;
   int fail_count = 0;
   int checks_done = 0;
   int reads = 0;
   always #12.5 MCLK_I = ~MCLK_I;
   port_input_and_interrupt_ops dut (.MCLK_I(MCLK_I), .SRST_I(SRST_I), .CE_I(1'b1),
      .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(SEL_I),
      .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .PORT_ADDR_O(PORT_ADDR_O),
      .PORT_RD_O(PORT_RD_O), .PORT_DATA_I(PORT_DATA_I), .MEM_ADDR_O(MEM_ADDR_O),
      .MEM_WDATA_O(MEM_WDATA_O), .MEM_WE_O(MEM_WE_O), .MEM_RD_O(MEM_RD_O),
      .MEM_RDATA_I(MEM_RDATA_I), .IRQ_REQ_I(IRQ_REQ_I), .IRQ_SERVICE_O(IRQ_SERVICE_O),
      .BUSY_O(BUSY_O));
   port_model far (.clk_i(MCLK_I), .rst_i(SRST_I), .port_addr_i(PORT_ADDR_O),
      .port_rd_i(PORT_RD_O), .mem_rd_i(MEM_RD_O), .mem_addr_i(MEM_ADDR_O),
      .port_data_o(PORT_DATA_I), .mem_rdata_o(MEM_RDATA_I));
   always @(posedge MCLK_I) begin
      if (PORT_RD_O === 1'b1) reads <= reads + 1;
      if (MEM_WE_O === 1'b1) begin
         wa <= MEM_ADDR_O;
         wd <= MEM_WDATA_O;
      end
      if (MEM_RD_O === 1'b1) ra <= MEM_ADDR_O;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge MCLK_I);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      ADR_I <= a;
      WE_I <= w;
      DAT_I <= d;
      SEL_I <= 4'hf;
      n = 0;
      // hold everything until ack is sampled
      while (ACK_O !== 1'b1 && n < 50) begin
         @(posedge MCLK_I);
         n++;
      end
      r = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      if (n == 50) begin
         fail_count++;
         report_and_stop;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(a, 1'b1, d, r);
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask
   task run(input logic [16:0] op);
      int n;
      wr(REG_INSTR, {15'h0, op});
      n = 0;
      @(posedge MCLK_I);
      while (BUSY_O !== 1'b0 && n < 200) begin
         @(posedge MCLK_I);
         n++;
      end
      if (n == 200) begin
         fail_count++;
         report_and_stop;
      end
   endtask
   initial begin
      repeat (3) @(posedge MCLK_I);
      SRST_I <= 1'b0;
      rchk(REG_STATUS, 32'h0);
      rchk(REG_SP, 32'h0);
      wr(8'hfc, 32'h1234);
      rchk(8'hfc, 32'h0);
      $display("test reset done");
      IRQ_REQ_I <= 1'b1;
      run(OP_IRQ_EN);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[ST_MASK], 1'b1);
      chk(IRQ_SERVICE_O, 1'b1);
      // idle gap stands for the trailing no-op
      run(OP_IRQ_DIS);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[ST_MASK], 1'b0);
      chk(IRQ_SERVICE_O, 1'b0);
      IRQ_REQ_I <= 1'b0;
      $display("test mask done");
      run({OP_IN_ACC, 2'd1, 6'h00, 1'b0, 1'b0});
      rchk(REG_ACC_BASE + 8'h04, 32'h0);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[2:1], 2'b10);
      run({OP_IN_ACC, 2'd2, 6'h3d, 1'b0, 1'b1});
      rchk(REG_ACC_BASE + 8'h18, 32'hf401);
      chk(PORT_ADDR_O, 6'h3d);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[2:1], 2'b01);
      $display("test accumulator input done");
      wr(REG_STRLEN, 32'h2);
      p0 = reads;
      run({OP_IN_STR, 2'd0, 6'h21, 1'b0, 1'b0});
      chk(reads - p0, 32'd4);
      for (int k = 0; k < 4; k++) begin
         rchk(REG_ACC_BASE + 8'(4 * k), {6'h21, 4'h0, 6'(2 + k)});
      end
      $display("test string input done");
      wb(REG_PC, 1'b0, 32'h0, p0);
      wr(REG_WORD2, 32'h0123);
      run({OP_IN_MEM, 4'h3, 8'h00});
      chk(PORT_ADDR_O, 6'h0c);
      rchk(REG_PC, p0 + 32'h2);
      chk(wa, 16'h0123);
      chk(wd, 16'h3006);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[6:5], 2'b00);
      wr(REG_WORD2, 32'h0100);
      run({OP_IN_MEM, 4'h8, 8'h80});
      chk(PORT_ADDR_O, 6'h20);
      rchk(REG_PC, p0 + 32'h4);
      chk(wa, p0 + 32'h102);
      chk(wd, 16'h8007);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[6:5], 2'b10);
      $display("test memory input done");
      wr(REG_SP, 32'h0040);
      wr(REG_STACK_TOP, 32'h0abc);
      run(OP_IRQ_RET);
      rchk(REG_PC, 32'h0abc);
      rchk(REG_SP, 32'h003e);
      chk(ra, 16'h003e);
      rchk(REG_STACK_TOP, 32'h5a64);
      $display("test return done");
      run(17'h00000);
      wb(REG_STATUS, 1'b0, 32'h0, q);
      chk(q[ST_BAD], 1'b1);
      $display("test bad opcode done");
      report_and_stop;
   end
endmodule
